// ==== pin_select_pkg.sv ====
/*
 * Shared constants and types for the remappable input pin selector block:
 * register map, field layout, reset values, channel table and the packed
 * carrier of routed peripheral inputs.
 * Assumes a 32-bit AHB-Lite register bus and 6-bit pin selectors.
 */
package pin_select_pkg;

   // Selector fields
   localparam int         SEL_W          = 6;
   localparam logic [5:0] SEL_RESET      = 6'h3f;
   localparam int         HI_LSB         = 8;
   localparam int         LO_LSB         = 0;
   localparam int         NUM_SEL_REGS   = 10;
   localparam int         NUM_CHANNELS   = 18;
   localparam int         SYNC_STAGES    = 3;

   // Register map, byte addresses on the bus
   localparam int         ADDR_W         = 8;
   localparam logic [7:0] STATUS_OFFSET  = 8'h00;
   localparam logic [7:0] SEL_OFFSET [NUM_SEL_REGS] = '{
      8'h24, 8'h28, 8'h2c, 8'h3c, 8'h44, 8'h48, 8'h4c, 8'h50, 8'h54, 8'h58
   };

   // Registers holding a low selector; bits 3 and 4 have an upper one only
   localparam logic [9:0] LO_PRESENT     = 10'h3e7;

   // Status register fields
   localparam int         STAT_LOCK_BIT    = 0;
   localparam int         STAT_REFUSED_BIT = 1;

   // Channel table: owning register and upper/lower field
   localparam logic [3:0] CH_REG [NUM_CHANNELS] = '{
      4'h0, 4'h0, 4'h1, 4'h1, 4'h2, 4'h2, 4'h3, 4'h4, 4'h5,
      4'h5, 4'h6, 4'h6, 4'h7, 4'h7, 4'h8, 4'h8, 4'h9, 4'h9
   };
   localparam logic [17:0] CH_HIGH       = 18'h2aaea;
   // Level shown while a channel is disconnected
   localparam logic [17:0] CH_IDLE       = 18'h0cfb0;

   // AHB-Lite encodings
   localparam logic [1:0] HTRANS_IDLE    = 2'h0;
   localparam logic [1:0] HTRANS_NONSEQ  = 2'h2;
   localparam logic       HRESP_OKAY     = 1'b0;

   // Routed peripheral inputs, channel 17 at the top down to channel 0
   typedef struct packed {
      logic sync2_clock_input;
      logic sync2_data_input;
      logic serial3_clear_to_send_input;
      logic sync1_slave_select_input;
      logic sync1_clock_input;
      logic sync1_data_input;
      logic serial2_clear_to_send_input;
      logic serial2_receive_input;
      logic serial1_clear_to_send_input;
      logic serial1_receive_input;
      logic serial3_receive_input;
      logic capture_unit_9;
      logic compare_fault_b_input;
      logic compare_fault_a_input;
      logic capture_unit_8;
      logic capture_unit_7;
      logic capture_unit_6;
      logic capture_unit_5;
   } peripheral_inputs_s;

endpackage

// ==== pin_input_mux.sv ====
/*
 * One selector-driven pin multiplexer: picks the filtered pin level whose
 * number the selector holds, or the channel's idle level.
 * Assumes pin levels are already synchronised to the system clock.
 */
`timescale 1ns/1ps

module pin_input_mux #(
   parameter int NUM_PINS = 48
) (
   // Pin levels
   input  wire logic [NUM_PINS-1:0] pin_level,
   // Selection
   input  wire logic [5:0]          sel,
   input  wire logic                idle_level,
   // Result
   output logic                     routed
);

   localparam logic [6:0] PIN_COUNT = 7'(NUM_PINS);

   logic [NUM_PINS-1:0] one_hot;

   // Decode keeps every index in range for strict elaboration
   genvar i;
   generate
      for (i = 0; i < NUM_PINS; i++) begin : g_dec
         assign one_hot[i] = (sel == 6'(i));
      end
   endgenerate

   // No pin of that number: stay idle, cut off from every pin
   always_comb begin
      if ({1'b0, sel} < PIN_COUNT) begin
         routed = |(one_hot & pin_level);
      end else begin
         routed = idle_level;
      end
   end

endmodule

// ==== input_pin_select_map.sv ====
/*
 * Remappable input pin routing: ten input-select registers on AHB-Lite,
 * each with one or two 6-bit selectors, steer remappable pins onto capture,
 * compare fault, serial and synchronous serial peripheral inputs.
 * Assumes pins are asynchronous to hclk and that the write-lock level comes
 * from same-clock control logic elsewhere in the unit.
 */
`timescale 1ns/1ps

// How it works
// - Register nine selects capture six and five
// - Register ten selects capture eight and seven
// - Register eleven selects fault B and A
// - Register fifteen selects capture nine only
// - Register seventeen selects serial three receive
// - Register eighteen selects serial one inputs
// - Register nineteen selects serial two inputs
// - Register twenty selects sync one clock, data
// - Register twenty-one: serial three CTS, sync select
// - Register twenty-two selects sync two clock, data
// - Unused bit positions always read zero
// - Writes ignored while write lock set
module input_pin_select_map #(
   parameter int NUM_PINS = 48
) (
   // Clock and reset
   input  wire logic                              hclk,
   input  wire logic                              hresetn,
   // AHB-Lite slave
   input  wire logic                              hsel,
   input  wire logic [31:0]                       haddr,
   input  wire logic [1:0]                        htrans,
   input  wire logic                              hwrite,
   input  wire logic [2:0]                        hsize,
   input  wire logic [31:0]                       hwdata,
   input  wire logic                              hready,
   output logic      [31:0]                       hrdata,
   output logic                                   hreadyout,
   output logic                                   hresp,
   // Lock from the unit's oscillator control
   input  wire logic                              pin_map_write_lock,
   // Remappable pins
   input  wire logic [NUM_PINS-1:0]               remappable_io_pin,
   // Routed peripheral inputs
   output pin_select_pkg::peripheral_inputs_s     peripheral_inputs
);

   // Selector value 63 must stay free to mean disconnected
   generate
      if (NUM_PINS < 1 || NUM_PINS > 63) begin : g_bad_pins
         $error("NUM_PINS must lie between 1 and 63");
      end
   endgenerate

   localparam int NR = pin_select_pkg::NUM_SEL_REGS;
   localparam int NC = pin_select_pkg::NUM_CHANNELS;
   localparam int SW = pin_select_pkg::SEL_W;

   // A bad package edit would silently misroute a peripheral
   generate
      if (pin_select_pkg::SEL_W != 6) begin : g_bad_sel_w
         $error("SEL_W must match the 6-bit selector ports");
      end
      if (pin_select_pkg::SYNC_STAGES != 3) begin : g_bad_sync
         $error("SYNC_STAGES must be 3 to match the pin synchronisers");
      end
      if (pin_select_pkg::ADDR_W != 8) begin : g_bad_addr_w
         $error("ADDR_W must be 8 to decode the byte offsets");
      end
      if (pin_select_pkg::NUM_CHANNELS != $bits(pin_select_pkg::peripheral_inputs_s)) begin : g_bad_nc
         $error("NUM_CHANNELS must equal the width of the peripheral carrier");
      end
      if (pin_select_pkg::LO_LSB + pin_select_pkg::SEL_W > pin_select_pkg::HI_LSB ||
          pin_select_pkg::HI_LSB + pin_select_pkg::SEL_W > 16) begin : g_bad_fields
         $error("Selector fields must not overlap and must fit the 16-bit register");
      end
      if (pin_select_pkg::STAT_LOCK_BIT == pin_select_pkg::STAT_REFUSED_BIT) begin : g_bad_stat
         $error("Status lock and refused bits must differ");
      end
      if (pin_select_pkg::SEL_RESET < NUM_PINS) begin : g_bad_reset_sel
         $error("Reset selector value must name no pin");
      end
   endgenerate

   // Offsets and the channel table must stay consistent
   genvar t;
   genvar u;
   generate
      for (t = 0; t < NR; t++) begin : g_reg_chk
         if (pin_select_pkg::SEL_OFFSET[t][1:0] != 2'h0) begin : g_bad_align
            $error("Selector register offsets must be word aligned");
         end
         if (pin_select_pkg::SEL_OFFSET[t] == pin_select_pkg::STATUS_OFFSET) begin : g_bad_clash
            $error("Selector register offset clashes with the status register");
         end
         for (u = t + 1; u < NR; u++) begin : g_dup
            if (pin_select_pkg::SEL_OFFSET[t] == pin_select_pkg::SEL_OFFSET[u]) begin : g_bad_dup
               $error("Two selector registers share one offset");
            end
         end
      end
      for (t = 0; t < NC; t++) begin : g_chan_chk
         if (pin_select_pkg::CH_REG[t] >= NR) begin : g_bad_reg
            $error("Channel table names a register that does not exist");
         end
         if (!pin_select_pkg::CH_HIGH[t] &&
             !pin_select_pkg::LO_PRESENT[pin_select_pkg::CH_REG[t]]) begin : g_bad_lo
            $error("Channel uses a lower selector its register does not have");
         end
         for (u = t + 1; u < NC; u++) begin : g_share
            if (pin_select_pkg::CH_REG[t] == pin_select_pkg::CH_REG[u] &&
                pin_select_pkg::CH_HIGH[t] == pin_select_pkg::CH_HIGH[u]) begin : g_bad_share
               $error("Two channels share one selector field");
            end
         end
      end
   endgenerate

   // Selector storage
   logic [SW-1:0] sel_hi_reg   [NR];
   logic [SW-1:0] sel_lo_reg   [NR];
   logic [SW-1:0] sel_hi_next  [NR];
   logic [SW-1:0] sel_lo_next  [NR];

   // Bus pipeline
   logic                                 wr_pending_reg;
   logic [pin_select_pkg::ADDR_W-1:0]    wr_addr_reg;
   logic [31:0]                          hrdata_reg;
   logic                                 hreadyout_reg;
   logic                                 hresp_reg;
   logic                                 refused_reg;
   logic                                 refused_next;

   // Pin conditioning
   logic [NUM_PINS-1:0] sync1_reg;
   logic [NUM_PINS-1:0] sync2_reg;
   logic [NUM_PINS-1:0] sync3_reg;
   logic [NUM_PINS-1:0] pin_level_reg;

   // Routing
   logic [NC-1:0] routed;
   logic [NC-1:0] routed_reg;

   // Decoded strobes
   logic          addr_phase;
   logic          wr_data_phase;
   logic          wr_allowed;
   logic [NR-1:0] wr_hit;
   logic          wr_status_hit;

   assign addr_phase    = hsel & hready & htrans[1];
   assign wr_data_phase = wr_pending_reg;
   assign wr_allowed    = wr_data_phase & ~pin_map_write_lock;

   // Write decode in the data phase
   always_comb begin
      wr_status_hit = (wr_addr_reg == pin_select_pkg::STATUS_OFFSET);
      for (int r = 0; r < NR; r++) begin
         wr_hit[r] = (wr_addr_reg == pin_select_pkg::SEL_OFFSET[r]);
      end
   end

   // Next selector values; also used for reads so back-to-back access sees new data
   always_comb begin
      for (int r = 0; r < NR; r++) begin
         sel_hi_next[r] = sel_hi_reg[r];
         sel_lo_next[r] = sel_lo_reg[r];
         if (wr_allowed && wr_hit[r]) begin
            sel_hi_next[r] = hwdata[pin_select_pkg::HI_LSB +: SW];
            if (pin_select_pkg::LO_PRESENT[r]) begin
               sel_lo_next[r] = hwdata[pin_select_pkg::LO_LSB +: SW];
            end
         end
      end
   end

   // Selector registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int r = 0; r < NR; r++) begin
            sel_hi_reg[r] <= pin_select_pkg::SEL_RESET;
            sel_lo_reg[r] <= pin_select_pkg::SEL_RESET;
         end
      end else begin
         for (int r = 0; r < NR; r++) begin
            sel_hi_reg[r] <= sel_hi_next[r];
            sel_lo_reg[r] <= sel_lo_next[r];
         end
      end
   end

   // Refused-write flag: a new refusal wins over a clear in the same cycle
   always_comb begin
      refused_next = refused_reg;
      if (wr_data_phase && !pin_map_write_lock && wr_status_hit &&
          hwdata[pin_select_pkg::STAT_REFUSED_BIT]) begin
         refused_next = 1'b0;
      end
      if (wr_data_phase && pin_map_write_lock && (|wr_hit)) begin
         refused_next = 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         refused_reg <= 1'b0;
      end else begin
         refused_reg <= refused_next;
      end
   end

   // Address phase capture for writes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pending_reg <= 1'b0;
         wr_addr_reg    <= '0;
      end else if (hready) begin
         wr_pending_reg <= addr_phase & hwrite;
         wr_addr_reg    <= haddr[pin_select_pkg::ADDR_W-1:0];
      end
   end

   // Read word for an address, gaps and unused bits forced to zero
   function automatic logic [31:0] read_word(input logic [pin_select_pkg::ADDR_W-1:0] a);
      logic [31:0] w;
      w = 32'h0000_0000;
      if (a == pin_select_pkg::STATUS_OFFSET) begin
         w[pin_select_pkg::STAT_LOCK_BIT]    = pin_map_write_lock;
         w[pin_select_pkg::STAT_REFUSED_BIT] = refused_next;
      end
      for (int r = 0; r < NR; r++) begin
         if (a == pin_select_pkg::SEL_OFFSET[r]) begin
            w[pin_select_pkg::HI_LSB +: SW] = sel_hi_next[r];
            if (pin_select_pkg::LO_PRESENT[r]) begin
               w[pin_select_pkg::LO_LSB +: SW] = sel_lo_next[r];
            end
         end
      end
      return w;
   endfunction

   // Read data registered at the address phase; zero wait states
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_reg <= 32'h0000_0000;
      end else if (addr_phase && !hwrite) begin
         hrdata_reg <= read_word(haddr[pin_select_pkg::ADDR_W-1:0]);
      end else begin
         hrdata_reg <= 32'h0000_0000;
      end
   end

   // Always ready, always OKAY
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout_reg <= 1'b1;
         hresp_reg     <= pin_select_pkg::HRESP_OKAY;
      end else begin
         hreadyout_reg <= 1'b1;
         hresp_reg     <= pin_select_pkg::HRESP_OKAY;
      end
   end

   assign hrdata    = hrdata_reg;
   assign hreadyout = hreadyout_reg;
   assign hresp     = hresp_reg;

   // Pin synchronisers; level accepted once stages two and three agree
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         sync3_reg <= '0;
      end else begin
         sync1_reg <= remappable_io_pin;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
      end
   end

   genvar p;
   generate
      for (p = 0; p < NUM_PINS; p++) begin : g_pin
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               pin_level_reg[p] <= 1'b0;
            end else if (sync2_reg[p] == sync3_reg[p]) begin
               pin_level_reg[p] <= sync3_reg[p];
            end
         end
      end
   endgenerate

   // One multiplexer per peripheral input
   genvar c;
   generate
      for (c = 0; c < NC; c++) begin : g_chan
         logic [SW-1:0] chan_sel;

         assign chan_sel = pin_select_pkg::CH_HIGH[c] ?
                           sel_hi_reg[pin_select_pkg::CH_REG[c]] :
                           sel_lo_reg[pin_select_pkg::CH_REG[c]];

         pin_input_mux #(
            .NUM_PINS   (NUM_PINS)
         ) u_mux (
            .pin_level  (pin_level_reg),
            .sel        (chan_sel),
            .idle_level (pin_select_pkg::CH_IDLE[c]),
            .routed     (routed[c])
         );
      end
   endgenerate

   // Output flops keep glitches of the mux away from the peripherals
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         routed_reg <= pin_select_pkg::CH_IDLE;
      end else begin
         routed_reg <= routed;
      end
   end

   // One field per channel keeps each peripheral's source visible
   assign peripheral_inputs.capture_unit_5              = routed_reg[0];
   assign peripheral_inputs.capture_unit_6              = routed_reg[1];
   assign peripheral_inputs.capture_unit_7              = routed_reg[2];
   assign peripheral_inputs.capture_unit_8              = routed_reg[3];
   assign peripheral_inputs.compare_fault_a_input       = routed_reg[4];
   assign peripheral_inputs.compare_fault_b_input       = routed_reg[5];
   assign peripheral_inputs.capture_unit_9              = routed_reg[6];
   assign peripheral_inputs.serial3_receive_input       = routed_reg[7];
   assign peripheral_inputs.serial1_receive_input       = routed_reg[8];
   assign peripheral_inputs.serial1_clear_to_send_input = routed_reg[9];
   assign peripheral_inputs.serial2_receive_input       = routed_reg[10];
   assign peripheral_inputs.serial2_clear_to_send_input = routed_reg[11];
   assign peripheral_inputs.sync1_data_input            = routed_reg[12];
   assign peripheral_inputs.sync1_clock_input           = routed_reg[13];
   assign peripheral_inputs.sync1_slave_select_input    = routed_reg[14];
   assign peripheral_inputs.serial3_clear_to_send_input = routed_reg[15];
   assign peripheral_inputs.sync2_data_input            = routed_reg[16];
   assign peripheral_inputs.sync2_clock_input           = routed_reg[17];

endmodule

// ==== pin_source_model.sv ====
/*
 * Pin-side partner: drives the remappable pins with levels the bench asks for.
 * Drives pins from hclk flops, synchronous to hclk; levels move one edge after a request.
 */
`timescale 1ns/1ps

module pin_source_model #(
   parameter int NUM_PINS = 8
) (
   // Clock and reset
   input  wire logic                hclk,
   input  wire logic                hresetn,
   // Wanted levels and pins
   input  wire logic [NUM_PINS-1:0] want,
   output logic      [NUM_PINS-1:0] pins
);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pins <= '0;
      end else begin
         pins <= want;
      end
   end
endmodule

// ==== pin_map_checker.sv ====
/*
 * Checker for the input pin selector: bus answers and routing stability.
 * Assumes hready is this slave's hreadyout and bound onto the top module.
 */
`timescale 1ns/1ps

module pin_map_checker #(
   parameter int NUM_PINS = 48
) (
   input wire logic                              hclk,
   input wire logic                              hresetn,
   input wire logic                              hsel,
   input wire logic [31:0]                       haddr,
   input wire logic [1:0]                        htrans,
   input wire logic                              hwrite,
   input wire logic                              hready,
   input wire logic [31:0]                       hrdata,
   input wire logic                              hreadyout,
   input wire logic                              hresp,
   input wire logic                              pin_map_write_lock,
   input wire logic [NUM_PINS-1:0]               remappable_io_pin,
   input wire pin_select_pkg::peripheral_inputs_s peripheral_inputs
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic                rd_q;
   logic                wr_q;
   logic [7:0]          a_q;
   logic [NUM_PINS-1:0] pin_q;
   logic [3:0]          quiet;
   logic                take;
   assign take = hsel & hready & htrans[1];
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_q <= 1'b0;
         wr_q <= 1'b0;
         a_q <= 8'h00;
      end else begin
         rd_q <= take & !hwrite;
         wr_q <= take & hwrite;
         a_q <= haddr[7:0];
      end
   end
   // Quiet count: routing may only move after a pin change or a write
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_q <= '0;
         quiet <= 4'h0;
      end else begin
         pin_q <= remappable_io_pin;
         if (remappable_io_pin != pin_q || wr_q) begin
            quiet <= 4'h0;
         end else if (quiet != 4'hf) begin
            quiet <= quiet + 4'h1;
         end
      end
   end
   a_ready_high: assert property (hreadyout) else $error("hreadyout low");
   a_resp_okay: assert property (hresp == pin_select_pkg::HRESP_OKAY) else $error("hresp not okay");
   a_rdata_idle: assert property (!rd_q |-> hrdata == 32'h0) else $error("hrdata outside read");
   a_reset_idle: assert property ($rose(hresetn) |-> peripheral_inputs == pin_select_pkg::CH_IDLE)
      else $error("inputs not idle after reset");
   a_unmapped_zero: assert property (rd_q && !(a_q inside {8'h00, 8'h24, 8'h28, 8'h2c, 8'h3c, 8'h44,
      8'h48, 8'h4c, 8'h50, 8'h54, 8'h58}) |-> hrdata == 32'h0) else $error("unmapped read not zero");
   a_spare_zero: assert property (rd_q |-> hrdata[31:14] == 18'h0 && hrdata[7:6] == 2'h0)
      else $error("spare bits not zero");
   a_upper_only: assert property (rd_q && (a_q == 8'h3c || a_q == 8'h44) |-> hrdata[7:0] == 8'h00)
      else $error("lower byte not zero");
   a_lock_shown: assert property (rd_q && a_q == pin_select_pkg::STATUS_OFFSET |->
      hrdata[0] == $past(pin_map_write_lock)) else $error("lock level not shown");
   a_quiet_stable: assert property (quiet == 4'hf |-> $stable(peripheral_inputs))
      else $error("routing moved without cause");
endmodule

bind input_pin_select_map pin_map_checker #(.NUM_PINS(NUM_PINS)) chk_u (.hclk, .hresetn, .hsel, .haddr,
   .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp, .pin_map_write_lock, .remappable_io_pin,
   .peripheral_inputs);

// ==== test_input_pin_select_map.sv ====
/*
 * Self-checking bench for the input pin selector over AHB-Lite.
 * Assumes the pin partner model and the bound checker.
 */
`timescale 1ns/1ps

module test_input_pin_select_map;
   localparam int NP = 8;
   logic                              hclk = 0;
   logic                              hresetn = 0;
   logic                              hsel = 0;
   logic                              hwrite = 0;
   logic                              lock = 0;
   logic                              rd_ph = 0;
   logic [31:0]                       haddr = 0;
   logic [31:0]                       hwdata = 0;
   logic [31:0]                       hrdata;
   logic [1:0]                        htrans = 0;
   logic [2:0]                        hsize = 3'h2;
   logic                              hreadyout;
   logic                              hresp;
   logic [NP-1:0]                     want = 0;
   logic [NP-1:0]                     pins;
   pin_select_pkg::peripheral_inputs_s outs;
   logic [5:0]                        hi [10];
   logic [5:0]                        lo [10];
   logic [31:0]                       exp_q [$];
   logic [31:0]                       d;
   int                                errors = 0;
   int                                samples_checked = 0;
   int                                cyc = 0;

   always #5 hclk = ~hclk;

   pin_source_model #(.NUM_PINS(NP)) pins_u (.hclk, .hresetn, .want, .pins);
   input_pin_select_map #(.NUM_PINS(NP)) dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .pin_map_write_lock(lock),
      .remappable_io_pin(pins), .peripheral_inputs(outs));

   task check(input string n, input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         errors++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask

   task close_out;
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // One single word transfer; a read notes its expected data
   task bus(input logic w, input logic [7:0] a, input logic [31:0] wd, input logic [31:0] e);
      hsel <= 1'b1;
      htrans <= pin_select_pkg::HTRANS_NONSEQ;
      hwrite <= w;
      haddr <= {24'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      if (!w) exp_q.push_back(e);
      htrans <= pin_select_pkg::HTRANS_IDLE;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
   endtask

   function automatic logic [31:0] rv(input int i);
      return {18'h0, hi[i], 2'h0, pin_select_pkg::LO_PRESENT[i] ? lo[i] : 6'h00};
   endfunction

   task route_chk;
      logic [17:0] e;
      logic [5:0]  s;
      for (int c = 0; c < 18; c++) begin
         s = pin_select_pkg::CH_HIGH[c] ? hi[pin_select_pkg::CH_REG[c]] : lo[pin_select_pkg::CH_REG[c]];
         e[c] = (s < NP) ? pins[s[2:0]] : pin_select_pkg::CH_IDLE[c];
      end
      check("routing", {14'h0, outs}, {14'h0, e});
   endtask

   task reset_test;
      hresetn <= 1'b0;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      for (int i = 0; i < 10; i++) begin
         hi[i] = pin_select_pkg::SEL_RESET;
         lo[i] = pin_select_pkg::SEL_RESET;
         bus(1'b0, pin_select_pkg::SEL_OFFSET[i], 32'h0, rv(i));
      end
      bus(1'b0, 8'h30, 32'h0, 32'h0);
      bus(1'b1, 8'h30, 32'hffffffff, 32'h0);
      bus(1'b0, 8'h30, 32'h0, 32'h0);
      route_chk;
      $display("reset test done");
   endtask

   always @(posedge hclk) begin
      if (rd_ph) check("hrdata", hrdata, exp_q.pop_front());
      rd_ph <= hresetn && hsel && hreadyout && htrans[1] && !hwrite;
      cyc++;
      if (cyc == 4000) begin
         errors++;
         close_out;
      end
   end

   initial begin
      void'($urandom(95));
      reset_test;
      for (int i = 0; i < 10; i++) begin
         d = $urandom;
         d[13:8] = 6'($urandom % 12);
         d[5:0] = 6'($urandom % 12);
         hi[i] = d[13:8];
         lo[i] = pin_select_pkg::LO_PRESENT[i] ? d[5:0] : 6'h3f;
         bus(1'b1, pin_select_pkg::SEL_OFFSET[i], d, 32'h0);
         bus(1'b0, pin_select_pkg::SEL_OFFSET[i], 32'h0, rv(i));
      end
      repeat (4) begin
         want <= NP'($urandom);
         repeat (10) @(posedge hclk);
         route_chk;
      end
      $display("routing test done");
      lock <= 1'b1;
      for (int i = 0; i < 10; i++) begin
         bus(1'b1, pin_select_pkg::SEL_OFFSET[i], 32'h0, 32'h0);
         bus(1'b0, pin_select_pkg::SEL_OFFSET[i], 32'h0, rv(i));
      end
      bus(1'b0, pin_select_pkg::STATUS_OFFSET, 32'h0, 32'h3);
      lock <= 1'b0;
      bus(1'b1, pin_select_pkg::STATUS_OFFSET, 32'h2, 32'h0);
      bus(1'b0, pin_select_pkg::STATUS_OFFSET, 32'h0, 32'h0);
      repeat (8) @(posedge hclk);
      route_chk;
      $display("lock test done");
      reset_test;
      close_out;
   end
endmodule
